// ### src/timer_channel.sv
/*
 * One 8-bit timer/event counter channel with interval, event, square-wave and PWM modes,
 * plus an optional 16-bit cascade input from a low channel.
 * Assumes all control ports are synchronous to clk_sys and held by software settings.
 */
`include "timer_map.svh"
`default_nettype none
module timer_channel (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Software settings.
    input  wire logic [7:0] mode_control,
    input  wire logic [2:0] tick_select,
    input  wire logic [7:0] match_write_data,
    input  wire logic       match_write,
    // Cascade link: this channel acts as the high byte when cascade_select is set.
    input  wire logic       low_tick,
    input  wire logic       low_match,
    input  wire logic       low_wrap,
    // Pins.
    input  wire logic       event_input_pin,
    input  wire logic       ext_tick,
    output logic            timer_output_pin,
    // Status.
    output logic [7:0]      count_value,
    output logic [7:0]      match_value,
    output logic            match_irq,
    output logic            count_tick,
    output logic            match_hit,
    output logic            count_wrap
);
    tick_if tk ();

    logic       count_enable_bit;
    logic       pwm_mode_select;
    logic       cascade_select;
    logic       output_force_high;
    logic       output_force_low;
    logic       invert_or_polarity_bit;
    logic       output_enable_bit;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] wr_q;
    logic [7:0] act_q;
    logic       pend_q;
    logic       late_q;
    logic       ff_q;
    logic       pwm_act_q;
    logic       step;
    logic       at_top;
    logic       overflow;
    logic       self_match;
    logic       hit;
    logic       pwm_end;
    logic       irq_q;
    logic       pin_d;
    timer_pkg::op_mode_e mode;

    // Mode control field decode.
    assign count_enable_bit       = mode_control[`MC_ENABLE_BIT];
    assign pwm_mode_select        = mode_control[`MC_PWM_BIT];
    assign cascade_select         = mode_control[`MC_CASCADE_BIT];
    assign output_force_high      = mode_control[`MC_FORCE_HI_BIT];
    assign output_force_low       = mode_control[`MC_FORCE_LO_BIT];
    assign invert_or_polarity_bit = mode_control[`MC_INVERT_BIT];
    assign output_enable_bit      = mode_control[`MC_OUT_EN_BIT];

    // Mode derived from the PWM bit and whether the tick source is the pin.
    always_comb begin
        if (pwm_mode_select) begin
            mode = timer_pkg::MODE_PWM;
        end else if (tick_select == `TICK_EV_FALL || tick_select == `TICK_EV_RISE) begin
            mode = timer_pkg::MODE_EVENT;
        end else begin
            mode = timer_pkg::MODE_INTERVAL;
        end
    end

    assign tk.select = tick_select;
    assign tk.run    = count_enable_bit;

    tick_gen u_tick (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .event_in (event_input_pin),
        .ext_tick (ext_tick),
        .tk       (tk)
    );

    // In cascade the high byte steps when the low byte wraps, using the low channel's tick.
    assign step       = cascade_select ? (low_tick & low_wrap) : tk.tick;
    assign at_top     = (count_q == `COUNT_TOP);
    assign overflow   = pwm_mode_select && step && at_top;
    assign self_match = (count_q == act_q);
    // Cascade match needs both bytes equal, checked on the low channel's tick.
    assign hit = cascade_select ? (low_tick & low_match & self_match)
                                : (tk.tick & self_match);
    // PWM ends its active phase on the step that brings the counter to the match value. Waiting
    // for count == match, as the clear-and-start modes do, would stretch the pulse by one tick.
    assign pwm_end = step && ((count_q + 8'h01) == act_q);

    // Counter: cleared on match outside PWM, free-running in PWM, held at zero when disabled.
    always_comb begin
        count_d = count_q;
        if (!count_enable_bit) begin
            count_d = `COUNT_RESET;
        end else if (!pwm_mode_select && hit) begin
            count_d = `COUNT_RESET;
        end else if (step) begin
            count_d = count_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= `COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // Written match value; reads always show the latest write.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= `MATCH_RESET;
        end else if (match_write) begin
            wr_q <= match_write_data;
        end
    end

    // Active compare value. Outside PWM it follows writes directly, since software must not
    // change it while running. In PWM a write is deferred to an overflow; a write taken while
    // the counter sits at FFH misses the coming overflow and waits for the second. A write taken
    // on the overflow edge itself counts that edge as the first overflow.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            act_q  <= `MATCH_RESET;
            pend_q <= 1'b0;
            late_q <= 1'b0;
        end else if (!pwm_mode_select || !count_enable_bit) begin
            act_q  <= match_write ? match_write_data : wr_q;
            pend_q <= 1'b0;
            late_q <= 1'b0;
        end else begin
            if (match_write) begin
                pend_q <= 1'b1;
                late_q <= at_top && !step;
            end else if (overflow && pend_q) begin
                if (late_q) begin
                    late_q <= 1'b0;
                end else begin
                    act_q  <= wr_q;
                    pend_q <= 1'b0;
                end
            end
        end
    end

    // Output flip-flop for the clear-and-start modes: forced by level bits, inverted on match.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ff_q <= 1'b0;
        end else if (!pwm_mode_select) begin
            if (output_force_low && !output_force_high) begin
                ff_q <= 1'b0;
            end else if (output_force_high && !output_force_low) begin
                ff_q <= 1'b1;
            end else if (count_enable_bit && hit && invert_or_polarity_bit) begin
                ff_q <= ~ff_q;
            end
        end
    end

    // PWM active phase: set on overflow, cleared at match, inactive while stopped.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pwm_act_q <= 1'b0;
        end else if (!count_enable_bit || !pwm_mode_select) begin
            pwm_act_q <= 1'b0;
        end else if (overflow) begin
            pwm_act_q <= (act_q != `COUNT_RESET);
        end else if (pwm_end) begin
            pwm_act_q <= 1'b0;
        end
    end

    // Interrupt pulse on every counted match.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= count_enable_bit && (pwm_mode_select ? pwm_end : hit);
        end
    end

    // Pin level; active-low PWM inverts the phase, and a disabled output is low.
    always_comb begin
        if (!output_enable_bit) begin
            pin_d = 1'b0;
        end else if (pwm_mode_select) begin
            pin_d = pwm_act_q ^ invert_or_polarity_bit;
        end else begin
            pin_d = ff_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer_output_pin <= 1'b0;
        end else begin
            timer_output_pin <= pin_d;
        end
    end

    assign count_value = count_q;
    assign match_value = wr_q;
    assign match_irq   = irq_q;
    assign count_tick  = tk.tick;
    assign match_hit   = count_enable_bit & (tk.tick & self_match);
    assign count_wrap  = at_top;

    // Steps of a clear-and-start match.
    sequence s_match;
        count_enable_bit && !pwm_mode_select && !cascade_select && tk.tick && self_match;
    endsequence

    a_match_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_match |=> (count_q == 8'h00) && match_irq)
        else $error("Match did not clear counter and raise interrupt.");

    a_stop_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !count_enable_bit |=> count_q == 8'h00)
        else $error("Counter not held at zero while disabled.");

    a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (count_enable_bit && !cascade_select && tk.tick && !self_match && $stable(mode_control))
        |=> count_q == $past(count_q) + 8'h01)
        else $error("Counter did not step on a tick.");

    a_square_flip: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_match and (invert_or_polarity_bit && !output_force_high && !output_force_low))
        |=> ff_q != $past(ff_q))
        else $error("Square-wave flip-flop not inverted on match.");

    a_force_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (!pwm_mode_select && output_force_low && !output_force_high) |=> !ff_q)
        else $error("Force-low did not clear the flip-flop.");

    a_pwm_stop: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (pwm_mode_select && !count_enable_bit) |=> !pwm_act_q)
        else $error("PWM phase active while stopped.");

    a_pwm_over: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (overflow && count_enable_bit && act_q != 8'h00) |=> pwm_act_q)
        else $error("Overflow did not start the active phase.");

    a_pwm_end: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (pwm_mode_select && count_enable_bit && pwm_end && !overflow) |=> !pwm_act_q)
        else $error("PWM phase not ended at the match step.");

    a_pin_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !output_enable_bit |=> !timer_output_pin)
        else $error("Output pin not low while disabled.");

    a_read_new: assert property (@(posedge clk_sys) disable iff (!rst_b)
        match_write |=> match_value == $past(match_write_data))
        else $error("Match read did not return the written value.");
endmodule : timer_channel
`default_nettype wire

// ### src/timer_map.svh
/*
 * Constants for the 8-bit timer/event counter channel: field positions, reset values and codes.
 * Assumes it is included by bare name from the design modules.
 */
//
// How it works
// - Clear-and-start mode: on match, clear counter, keep counting, raise match interrupt.
// - Interval mode interrupts every (match_value + 1) count clocks.
// - Counting starts when count_enable_bit is 1 and stops when 0.
// - Count_enable_bit low forces counter to zero and holds it.
// - Event mode counts external edges; code 00H falling, 01H rising.
// - Event mode interrupts after (match_value + 1) valid edges, then clears.
// - Square-wave mode: each match inverts output flip-flop, interrupts, clears counter.
// - Square wave has 50% duty, period twice (match_value + 1) count clocks.
// - pwm_mode_select 1 selects PWM; polarity bit selects active level.
// - PWM output stays inactive after start until the first overflow.
// - PWM overflow drives output active until counter equals match; interrupt then.
// - PWM match returns output inactive until next overflow; repeats while enabled.
// - PWM period 256 count clocks, active width match_value clocks.
// - Clearing count_enable_bit drives PWM output inactive.
// - PWM match write before FFH edge loads at next overflow, else second.
// - Reading match_value returns the newly written value while still pending.
// - output_enable_bit gates the waveform onto timer_output_pin.
// - output_enable_bit 0 holds timer_output_pin low.
// - cascade_select selects 16-bit mode; two match values form one compare.
// - Outside PWM, force bits: 01 clears, 10 sets, 00 holds flip-flop.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Mode control field positions.
`define MC_ENABLE_BIT   7
`define MC_PWM_BIT      6
`define MC_CASCADE_BIT  4
`define MC_FORCE_HI_BIT 3
`define MC_FORCE_LO_BIT 2
`define MC_INVERT_BIT   1
`define MC_OUT_EN_BIT   0

// Reset values and the counter top value.
`define MODE_RESET      8'h00
`define TICK_RESET      3'h0
`define MATCH_RESET     8'h00
`define COUNT_RESET     8'h00
`define COUNT_TOP       8'hFF

// Tick select codes.
`define TICK_EV_FALL    3'h0
`define TICK_EV_RISE    3'h1
`define TICK_DIV1       3'h2
`define TICK_DIV2       3'h3
`define TICK_DIV4       3'h4
`define TICK_DIV64      3'h5
`define TICK_DIV256     3'h6
`define TICK_EXT        3'h7

// Prescaler width; divides clk_sys by up to 256.
`define PRESCALE_W      8

`endif

// ### src/timer_pkg.sv
/*
 * Types shared by the timer channel modules.
 * Assumes timer_map.svh is reachable on the include path.
 */
`default_nettype none
package timer_pkg;
    // Channel operating mode, derived from the mode and tick fields.
    typedef enum logic [1:0] {
        MODE_INTERVAL = 2'b00,
        MODE_EVENT    = 2'b01,
        MODE_PWM      = 2'b10
    } op_mode_e;
endpackage : timer_pkg
`default_nettype wire

// ### src/tick_if.sv
/*
 * Interface carrying the count tick from the tick generator to the channel core.
 * Assumes one clock domain, clk_sys.
 */
`default_nettype none
interface tick_if;
    logic       tick;
    logic [2:0] select;
    logic       run;
    modport gen  (output tick, input select, input run);
    modport core (input tick, output select, output run);
endinterface : tick_if
`default_nettype wire

// ### src/tick_gen.sv
/*
 * Count tick generator: internal clock divider and synchronised external edge detector.
 * Assumes event_in is synchronous-sampled in clk_sys; no second clock.
 */
`include "timer_map.svh"
`default_nettype none
module tick_gen (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // External event pin and extra tick source.
    input  wire logic event_in,
    input  wire logic ext_tick,
    // Tick carrier.
    tick_if.gen       tk
);
    logic [`PRESCALE_W-1:0] pre_q;
    logic                   sync1_q;
    logic                   sync2_q;
    logic                   last_q;
    logic                   edge_ok;
    logic                   div_tick;

    // Free-running prescaler; cleared while stopped so a start always begins a fresh period.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= '0;
        end else if (!tk.run) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Two-flop synchroniser, then an edge history flop; only the second stage is inspected.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q  <= 1'b0;
        end else begin
            sync1_q <= event_in;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
        end
    end

    // One pulse per selected edge.
    assign edge_ok = (tk.select == `TICK_EV_RISE) ? (sync2_q & ~last_q) : (~sync2_q & last_q);

    // Tick selection; divider outputs pulse once per period.
    always_comb begin
        case (tk.select)
            `TICK_DIV1:   div_tick = 1'b1;
            `TICK_DIV2:   div_tick = (pre_q[0] == 1'b1);
            `TICK_DIV4:   div_tick = (pre_q[1:0] == 2'h3);
            `TICK_DIV64:  div_tick = (pre_q[5:0] == 6'h3F);
            `TICK_DIV256: div_tick = (pre_q == 8'hFF);
            `TICK_EXT:    div_tick = ext_tick;
            default:      div_tick = edge_ok;
        endcase
    end

    assign tk.tick = tk.run & div_tick;

    a_edge_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (tk.select == `TICK_EV_RISE && tk.tick) |=> !tk.tick)
        else $error("Two ticks from one input edge.");
endmodule : tick_gen
`default_nettype wire

// ### testbench/event_pulse_source.sv
/*
 * Model of the external pulse source that drives the channel's event input pin.
 * Assumes it shares clk_sys with the bench; a go pulse starts a burst of whole pulses.
 */
`default_nettype none
module event_pulse_source (
    // Clock.
    input  wire logic       clk_sys,
    // Burst request.
    input  wire logic       go,
    input  wire logic [7:0] pulses,
    // Pin side.
    output logic            event_pin,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q = 8'h00;
    logic [2:0] phase_q = 3'h0;

    // Each pulse stays high four cycles and low four, so the synchroniser never merges two edges.
    always @(posedge clk_sys) begin
        if (go) begin
            left_q <= pulses;
            phase_q <= 3'h0;
        end else if (left_q != 8'h00) begin
            phase_q <= phase_q + 3'h1;
            if (phase_q == 3'h7) begin
                left_q <= left_q - 8'h01;
            end
        end
    end

    // The source drives the pin low between bursts, so an idle line never shows a stale edge.
    assign event_pin = (left_q != 8'h00) && !phase_q[2];
    assign busy = (left_q != 8'h00);
endmodule : event_pulse_source
`default_nettype wire

// ### testbench/eight_bit_timer_event_counter_tb_top.sv
/*
 * Self-checking bench for the timer channel: interval table, square wave, forcing, PWM and events.
 * Assumes the design sources and the pulse source model are compiled before it.
 */
`default_nettype none
module eight_bit_timer_event_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [2:0]  sel;
        logic [7:0]  n;
        logic [15:0] irqs;
    } row_s;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  mode_control = 8'h00;
    logic [2:0]  tick_select = 3'h2;
    logic [7:0]  match_write_data = 8'h00;
    logic        match_write = 1'b0;
    logic        go = 1'b0;
    logic [7:0]  pulses = 8'h00;
    logic        event_pin;
    logic        busy;
    logic        timer_output_pin;
    logic [7:0]  count_value;
    logic [7:0]  match_value;
    logic        match_irq;
    logic        cas_tick = 1'b0;
    logic        cas_match = 1'b0;
    logic        cas_wrap = 1'b0;
    logic        tick_seen;
    logic        hit_seen;
    logic        wrap_seen;
    logic        last_pin = 1'b0;
    logic [15:0] irq_cnt = 16'h0000;
    logic [15:0] hi_cnt = 16'h0000;
    logic [15:0] tog_cnt = 16'h0000;
    int          fail_count = 0;
    int          checked = 0;
    row_s        rows [6];
    logic [7:0]  sq [2];
    logic [8:0]  frc [5];

    timer_channel dut_u (
        .clk_sys          (clk_sys),
        .rst_b            (rst_b),
        .mode_control     (mode_control),
        .tick_select      (tick_select),
        .match_write_data (match_write_data),
        .match_write      (match_write),
        .low_tick         (cas_tick),
        .low_match        (cas_match),
        .low_wrap         (cas_wrap),
        .event_input_pin  (event_pin),
        .ext_tick         (1'b0),
        .timer_output_pin (timer_output_pin),
        .count_value      (count_value),
        .match_value      (match_value),
        .match_irq        (match_irq),
        .count_tick       (tick_seen),
        .match_hit        (hit_seen),
        .count_wrap       (wrap_seen)
    );

    event_pulse_source src_u (
        .clk_sys   (clk_sys),
        .go        (go),
        .pulses    (pulses),
        .event_pin (event_pin),
        .busy      (busy)
    );

    // Free-running 100 MHz clock.
    always #5 clk_sys = ~clk_sys;

    // Window counters; an unknown output turns them unknown, so it can never pass.
    always @(posedge clk_sys) begin
        irq_cnt <= irq_cnt + 16'(match_irq);
        hi_cnt <= hi_cnt + 16'(timer_output_pin);
        tog_cnt <= tog_cnt + 16'(timer_output_pin != last_pin);
        last_pin <= timer_output_pin;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cycles

    // Clears the counters at a falling edge, then lets n rising edges be counted.
    task automatic window(input int n);
        irq_cnt = 16'h0000;
        hi_cnt = 16'h0000;
        tog_cnt = 16'h0000;
        cycles(n);
    endtask : window

    task automatic set_match(input logic [7:0] v);
        match_write_data = v;
        match_write = 1'b1;
        cycles(1);
        match_write = 1'b0;
    endtask : set_match

    // Bounded wait for a counter value; running out shows up as a mismatch.
    task automatic wait_count(input logic [7:0] v);
        int n;
        n = 0;
        while (count_value !== v && n < 1000) begin
            cycles(1);
            n++;
        end
        check("count reached", {8'h00, count_value}, {8'h00, v});
    endtask : wait_count

    task automatic send(input logic [7:0] k);
        int n;
        n = 0;
        pulses = k;
        go = 1'b1;
        cycles(1);
        go = 1'b0;
        cycles(1);
        while (busy !== 1'b0 && n < 4000) begin
            cycles(1);
            n++;
        end
        cycles(8);
    endtask : send

    // Main sequence: interval table first, then the hand-written cases.
    initial begin
        rows = '{'{3'h2, 8'h00, 16'h0300}, '{3'h2, 8'h02, 16'h0100}, '{3'h3, 8'h03, 16'h0060},
                 '{3'h4, 8'h05, 16'h0020}, '{3'h5, 8'h01, 16'h0006}, '{3'h6, 8'h02, 16'h0001}};
        sq = '{8'h0B, 8'h07};
        frc = '{9'h005, 9'h001, 9'h109, 9'h10D, 9'h101};
        cycles(16);
        rst_b = 1'b1;
        cycles(2);
        check("count after reset", {8'h00, count_value}, 16'h0000);
        check("pin after reset", 16'(timer_output_pin), 16'h0000);
        foreach (rows[i]) begin
            mode_control = 8'h00;
            tick_select = rows[i].sel;
            set_match(rows[i].n);
            mode_control = 8'h80;
            cycles(768);
            window(768);
            check("interval irqs", irq_cnt, rows[i].irqs);
        end
        mode_control = 8'h00;
        cycles(2);
        check("count stopped", {8'h00, count_value}, 16'h0000);
        window(50);
        check("irqs stopped", irq_cnt, 16'h0000);
        check("tick stopped", 16'(tick_seen), 16'h0000);
        check("hit stopped", 16'(hit_seen), 16'h0000);
        // Square wave from both start levels; a 100-cycle window holds whole periods of 10.
        tick_select = 3'h2;
        set_match(8'h04);
        foreach (sq[j]) begin
            mode_control = sq[j];
            cycles(3);
            check("square start level", 16'(timer_output_pin), {15'h0000, sq[j][3]});
            mode_control = 8'h83;
            cycles(10);
            window(100);
            check("square toggles", tog_cnt, 16'h0014);
            check("square irqs", irq_cnt, 16'h0014);
            check("square high time", hi_cnt, 16'h0032);
        end
        mode_control = 8'h82;
        // The pin is registered, so the first sample after a change still shows the old level.
        cycles(2);
        window(50);
        check("pin disabled", hi_cnt, 16'h0000);
        foreach (frc[j]) begin
            mode_control = frc[j][7:0];
            cycles(3);
            check("forced level", 16'(timer_output_pin), {15'h0000, frc[j][8]});
        end
        // PWM with a width of 64, then an early and a late rewrite.
        mode_control = 8'h00;
        set_match(8'h40);
        mode_control = 8'h41;
        cycles(2);
        mode_control = 8'hC1;
        window(250);
        check("pwm before overflow", hi_cnt, 16'h0000);
        wait_count(8'h40);
        check("pwm match hit", 16'(hit_seen), 16'h0001);
        wait_count(8'h80);
        window(256);
        check("pwm width", hi_cnt, 16'h0040);
        check("pwm irqs", irq_cnt, 16'h0001);
        check("pwm edges", tog_cnt, 16'h0002);
        wait_count(8'h10);
        set_match(8'h80);
        cycles(1);
        check("early write read", {8'h00, match_value}, 16'h0080);
        wait_count(8'hC0);
        window(256);
        check("early write width", hi_cnt, 16'h0080);
        wait_count(8'hFF);
        check("wrap flag", 16'(wrap_seen), 16'h0001);
        check("tick running", 16'(tick_seen), 16'h0001);
        set_match(8'h20);
        window(200);
        check("late write width", hi_cnt, 16'h0080);
        check("late write read", {8'h00, match_value}, 16'h0020);
        window(256);
        check("late write second", hi_cnt, 16'h0020);
        mode_control = 8'hC3;
        wait_count(8'h80);
        window(256);
        check("low active high time", hi_cnt, 16'h00E0);
        mode_control = 8'hC2;
        cycles(2);
        window(256);
        check("pwm gated off", hi_cnt, 16'h0000);
        mode_control = 8'h43;
        cycles(3);
        check("pwm stopped level", 16'(timer_output_pin), 16'h0001);
        // Event counting on rising, then falling edges of the pin.
        mode_control = 8'h00;
        tick_select = 3'h1;
        set_match(8'h03);
        mode_control = 8'h80;
        window(1);
        send(8'h04);
        check("rising irqs", irq_cnt, 16'h0001);
        check("rising wrap", {8'h00, count_value}, 16'h0000);
        send(8'h02);
        check("rising count", {8'h00, count_value}, 16'h0002);
        mode_control = 8'h00;
        tick_select = 3'h0;
        set_match(8'h01);
        mode_control = 8'h80;
        window(1);
        send(8'h03);
        check("falling irqs", irq_cnt, 16'h0001);
        check("falling count", {8'h00, count_value}, 16'h0001);
        // Cascade high byte: the low channel is modelled as wrapping on every tick.
        mode_control = 8'h00;
        cas_tick = 1'b1;
        cas_match = 1'b1;
        cas_wrap = 1'b1;
        set_match(8'h02);
        mode_control = 8'h90;
        cycles(6);
        window(30);
        check("cascade irqs", irq_cnt, 16'h000A);
        cas_match = 1'b0;
        cycles(2);
        window(30);
        check("cascade low miss", irq_cnt, 16'h0000);
        mode_control = 8'h00;
        cas_tick = 1'b0;
        cas_wrap = 1'b0;
        tally_and_finish();
    end

    // The sequence needs about 12000 cycles; 60000 leaves ample margin.
    initial begin
        #600us;
        fail_count++;
        tally_and_finish();
    end
endmodule : eight_bit_timer_event_counter_tb_top
`default_nettype wire
